// >>> include/amp_ctrl_params.svh
// register indices, field positions, reset values and timing counts for the amplifier control block
// assumes nothing beyond a 100 MHz system clock
`ifndef AMP_CTRL_PARAMS_SVH
`define AMP_CTRL_PARAMS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define REG_AMP_CTRL 3'h1
`define REG_ATTACK 3'h2
`define REG_RELEASE 3'h3
`define REG_MODE_MONO 3'h4
`define REG_PAIR_ONE 3'h5
`define REG_PAIR_TWO 3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_BYPASS 0
`define BIT_SPK_EN 1
`define BIT_RIGHT_EN 2
`define BIT_LEFT_EN 3
`define BIT_SOFT_SD 4
`define BIT_LIM_EN 5
`define BIT_SPK_GAIN 7
`define BIT_FORCE_UNITY 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_AMP_CTRL 8'h00
`define RST_ATTACK 8'h25
`define RST_RELEASE 8'h57
`define RST_MODE_MONO 8'h0d
`define RST_PAIR_ONE 8'h0d
`define RST_PAIR_TWO 8'h0d
`define VOL_UNITY 5'h0d
`define MODE_MUTE 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define ATTACK_BASE_US 1280
`define RELEASE_BASE_US 1280
`define ATTACK_BASE_CYC (`ATTACK_BASE_US * `CLK_MHZ)
`define RELEASE_BASE_CYC (`RELEASE_BASE_US * `CLK_MHZ)

`endif

// >>> include/amp_ctrl_pkg.sv
// types shared by the amplifier control files
// assumes nothing about its surroundings
package amp_ctrl_pkg;

  typedef logic [4:0] vol_code_t;

  typedef enum logic [7:0] {
    MUX_MONO = 8'h01,
    MUX_DIFF_ONE = 8'h02,
    MUX_DIFF_TWO = 8'h04,
    MUX_STEREO_ONE = 8'h08,
    MUX_STEREO_TWO = 8'h10,
    MUX_DIFF_SUM = 8'h20,
    MUX_SE_SUM = 8'h40,
    MUX_MUTE = 8'h80
  } mux_mode_t;

  typedef enum logic [2:0] {
    SLEW_IDLE = 3'h1,
    SLEW_WAIT = 3'h2,
    SLEW_STEP = 3'h4
  } slew_state_t;

endpackage

// >>> hw/vol_slew.sv
// one volume channel that slews its applied code toward a target
// assumes a one-cycle write of the target and single clock domain
`timescale 1ns/10ps
`include "amp_ctrl_params.svh"
module vol_slew #(
  parameter int unsigned ATTACK_CYC = 128000,
  parameter int unsigned RELEASE_CYC = 128000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // control
  input wire logic limit_en_i,
  input wire logic [4:0] attack_sel_i,
  input wire logic [4:0] release_sel_i,
  input wire logic [4:0] target_i,
  // applied code
  output logic [4:0] applied_o
);

  // ----------------------------------------
  // step timer and slew machine
  // ----------------------------------------
  // step period scales with the selected code plus one times the base period
  amp_ctrl_pkg::slew_state_t state_r;
  logic [31:0] timer_r;
  logic [31:0] period;
  logic going_down;

  always_comb begin
    going_down = target_i < applied_o;
    if (going_down) begin
      period = ATTACK_CYC * ({27'h0, attack_sel_i} + 32'h1);
    end else begin
      period = RELEASE_CYC * ({27'h0, release_sel_i} + 32'h1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_r <= amp_ctrl_pkg::SLEW_IDLE;
      timer_r <= 32'h0;
      applied_o <= `VOL_UNITY;
    end else if (!limit_en_i) begin
      state_r <= amp_ctrl_pkg::SLEW_IDLE;
      timer_r <= 32'h0;
      applied_o <= target_i;
    end else begin
      unique case (state_r)
        amp_ctrl_pkg::SLEW_IDLE: begin
          timer_r <= 32'h0;
          if (target_i != applied_o) begin
            state_r <= amp_ctrl_pkg::SLEW_WAIT;
          end
        end
        amp_ctrl_pkg::SLEW_WAIT: begin
          timer_r <= timer_r + 32'h1;
          if (target_i == applied_o) begin
            state_r <= amp_ctrl_pkg::SLEW_IDLE;
          end else if (timer_r + 32'h1 >= period) begin
            state_r <= amp_ctrl_pkg::SLEW_STEP;
          end
        end
        amp_ctrl_pkg::SLEW_STEP: begin
          timer_r <= 32'h0;
          if (going_down) begin
            applied_o <= applied_o - 5'h1;
          end else if (target_i != applied_o) begin
            applied_o <= applied_o + 5'h1;
          end
          state_r <= amp_ctrl_pkg::SLEW_IDLE;
        end
      endcase
    end
  end

endmodule // vol_slew

// >>> hw/amp_power_gain_control.sv
// register bank and decode for the amplifier power, gain and volume controls
// assumes a serial front end that presents a completed byte write as a one-cycle strobe
//
// Summary of operation
// - bypass set kills speaker, closes bypass switches
// - separate enable bits for four sections
// - soft shutdown turns off all sections but bypass
// - enable pin low holds everything off
// - registers survive shutdown; reset only at power-up
// - charge pump runs when any phone enabled
// - speaker always takes left plus right sum
// - speaker enable bit drives speaker stage
// - speaker gain bit picks 6 or 12 dB
// - left and right phone enables from bits
// - phone gain from attenuation code and force
// - phone gain code steps; force gives unity
// - mode picks which volume code applies
// - three five-bit tapered volume codes
// - volume codes in low bits of 4,5,6
// - limiter slews volume at attack/release rates
// - bypass skips speaker volume, phones stay usable
// - volume fields reset to unity code
`timescale 1ns/10ps
`include "amp_ctrl_params.svh"
module amp_power_gain_control #(
  parameter int unsigned ATTACK_CYC = `ATTACK_BASE_CYC,
  parameter int unsigned RELEASE_CYC = `RELEASE_BASE_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // completed write from the serial front end
  input wire logic wr_strobe_i,
  input wire logic [2:0] wr_index_i,
  input wire logic [7:0] wr_data_i,
  // device pin
  input wire logic enable_pin_i,
  // power enables
  output logic speaker_enable_o,
  output logic left_phone_enable_o,
  output logic right_phone_enable_o,
  output logic bypass_switch_o,
  output logic charge_pump_enable_o,
  output logic bias_enable_o,
  // speaker path
  output logic speaker_sum_select_o,
  output logic speaker_gain_high_o,
  output logic speaker_volume_bypass_o,
  // phone path
  output logic [3:0] phone_gain_code_o,
  // volume
  output logic [7:0] mux_mode_o,
  output logic [4:0] mono_volume_code_o,
  output logic [4:0] pair_one_volume_code_o,
  output logic [4:0] pair_two_volume_code_o,
  output logic [4:0] active_volume_code_o,
  output logic [4:0] applied_volume_o,
  // register readback
  output logic soft_shutdown_o,
  output logic limiter_enable_o
);

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  // the supply reset is the only reset; shutdown never touches these
  logic [7:0] amp_ctrl_r;
  logic [7:0] attack_r;
  logic [7:0] release_r;
  logic [7:0] mode_mono_r;
  logic [7:0] pair_one_r;
  logic [7:0] pair_two_r;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      amp_ctrl_r <= `RST_AMP_CTRL;
      attack_r <= `RST_ATTACK;
      release_r <= `RST_RELEASE;
      mode_mono_r <= `RST_MODE_MONO;
      pair_one_r <= `RST_PAIR_ONE;
      pair_two_r <= `RST_PAIR_TWO;
    end else if (wr_strobe_i) begin
      unique case (wr_index_i)
        `REG_AMP_CTRL: amp_ctrl_r <= wr_data_i;
        `REG_ATTACK: attack_r <= wr_data_i;
        `REG_RELEASE: release_r <= wr_data_i;
        `REG_MODE_MONO: mode_mono_r <= wr_data_i;
        `REG_PAIR_ONE: pair_one_r <= wr_data_i;
        `REG_PAIR_TWO: pair_two_r <= wr_data_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic voice_bypass_select;
  logic soft_shutdown;
  logic left_phone_enable;
  logic right_phone_enable;
  logic spk_enable_bit;
  logic phone_gain_force_unity;
  logic [2:0] phone_attenuation_code;
  logic [2:0] mode_code;
  logic powered;
  logic [7:0] mode_nxt;
  logic [4:0] active_nxt;

  always_comb begin
    voice_bypass_select = amp_ctrl_r[`BIT_BYPASS];
    spk_enable_bit = amp_ctrl_r[`BIT_SPK_EN];
    right_phone_enable = amp_ctrl_r[`BIT_RIGHT_EN];
    left_phone_enable = amp_ctrl_r[`BIT_LEFT_EN];
    soft_shutdown = amp_ctrl_r[`BIT_SOFT_SD];
    phone_gain_force_unity = pair_one_r[`BIT_FORCE_UNITY];
    phone_attenuation_code = pair_two_r[7:5];
    mode_code = mode_mono_r[7:5];
    // the pin wins over every section enable; soft shutdown over all but the bypass switch
    powered = enable_pin_i && !soft_shutdown;
  end

  // mode code to one-hot mux select, and the volume that mode uses
  always_comb begin
    unique case (mode_code)
      3'h0: mode_nxt = amp_ctrl_pkg::MUX_MONO;
      3'h1: mode_nxt = amp_ctrl_pkg::MUX_DIFF_ONE;
      3'h2: mode_nxt = amp_ctrl_pkg::MUX_DIFF_TWO;
      3'h3: mode_nxt = amp_ctrl_pkg::MUX_STEREO_ONE;
      3'h4: mode_nxt = amp_ctrl_pkg::MUX_STEREO_TWO;
      3'h5: mode_nxt = amp_ctrl_pkg::MUX_DIFF_SUM;
      3'h6: mode_nxt = amp_ctrl_pkg::MUX_SE_SUM;
      3'h7: mode_nxt = amp_ctrl_pkg::MUX_MUTE;
    endcase
    unique case (mode_code)
      3'h0: active_nxt = mode_mono_r[4:0];
      3'h2, 3'h4: active_nxt = pair_two_r[4:0];
      3'h1, 3'h3, 3'h5, 3'h6: active_nxt = pair_one_r[4:0];
      3'h7: active_nxt = `VOL_UNITY;
    endcase
  end

  // ----------------------------------------
  // limiter slew of the applied volume
  // ----------------------------------------
  // only the code in use is slewed; it is five bits over the tapered table
  logic [4:0] slewed;

  vol_slew #(
    .ATTACK_CYC(ATTACK_CYC),
    .RELEASE_CYC(RELEASE_CYC)
  ) u_slew (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .limit_en_i(release_r[`BIT_LIM_EN]),
    .attack_sel_i(attack_r[7:3]),
    .release_sel_i(release_r[7:3]),
    .target_i(active_nxt),
    .applied_o(slewed)
  );

  // ----------------------------------------
  // power outputs
  // ----------------------------------------
  // outputs follow the register one cycle after the write lands
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      speaker_enable_o <= 1'b0;
      left_phone_enable_o <= 1'b0;
      right_phone_enable_o <= 1'b0;
      bypass_switch_o <= 1'b0;
      charge_pump_enable_o <= 1'b0;
      bias_enable_o <= 1'b0;
    end else begin
      speaker_enable_o <= powered && spk_enable_bit && !voice_bypass_select;
      left_phone_enable_o <= powered && left_phone_enable;
      right_phone_enable_o <= powered && right_phone_enable;
      // bypass switch is passive, so soft shutdown leaves it alone; the pin does not
      bypass_switch_o <= enable_pin_i && voice_bypass_select;
      charge_pump_enable_o <= powered && (left_phone_enable || right_phone_enable);
      bias_enable_o <= powered;
    end
  end

  // ----------------------------------------
  // gain outputs
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      speaker_sum_select_o <= 1'b1;
      speaker_gain_high_o <= 1'b0;
      speaker_volume_bypass_o <= 1'b0;
      phone_gain_code_o <= 4'h0;
    end else begin
      speaker_sum_select_o <= 1'b1;
      speaker_gain_high_o <= pair_one_r[`BIT_SPK_GAIN];
      speaker_volume_bypass_o <= voice_bypass_select;
      // any code with the force bit gives unity, so collapse the low bits
      phone_gain_code_o <= phone_gain_force_unity ? 4'h8 : {1'b0, phone_attenuation_code};
    end
  end

  // ----------------------------------------
  // volume and mode outputs
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mux_mode_o <= amp_ctrl_pkg::MUX_MONO;
      mono_volume_code_o <= `VOL_UNITY;
      pair_one_volume_code_o <= `VOL_UNITY;
      pair_two_volume_code_o <= `VOL_UNITY;
      active_volume_code_o <= `VOL_UNITY;
      applied_volume_o <= `VOL_UNITY;
    end else begin
      mux_mode_o <= mode_nxt;
      mono_volume_code_o <= mode_mono_r[4:0];
      pair_one_volume_code_o <= pair_one_r[4:0];
      pair_two_volume_code_o <= pair_two_r[4:0];
      active_volume_code_o <= active_nxt;
      applied_volume_o <= slewed;
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      soft_shutdown_o <= 1'b0;
      limiter_enable_o <= 1'b0;
    end else begin
      soft_shutdown_o <= soft_shutdown;
      limiter_enable_o <= release_r[`BIT_LIM_EN];
    end
  end

endmodule // amp_power_gain_control

// >>> sim/amp_ctrl_properties.sv
// checker for the amplifier control outputs
// assumes a bind onto amp_power_gain_control, one clock domain
`timescale 1ns/10ps
module amp_ctrl_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // watched inputs
  input wire logic wr_strobe_i,
  input wire logic [2:0] wr_index_i,
  input wire logic [7:0] wr_data_i,
  input wire logic enable_pin_i,
  // watched outputs
  input wire logic speaker_enable_o,
  input wire logic left_phone_enable_o,
  input wire logic right_phone_enable_o,
  input wire logic bypass_switch_o,
  input wire logic charge_pump_enable_o,
  input wire logic bias_enable_o,
  input wire logic speaker_sum_select_o,
  input wire logic speaker_gain_high_o,
  input wire logic speaker_volume_bypass_o,
  input wire logic [3:0] phone_gain_code_o,
  input wire logic [7:0] mux_mode_o,
  input wire logic [4:0] mono_volume_code_o,
  input wire logic soft_shutdown_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic amps_on;
  assign amps_on = speaker_enable_o | left_phone_enable_o | right_phone_enable_o | charge_pump_enable_o;
  // ----
  // assertions
  // ----
  a_bypass_kills_spk: assert property (bypass_switch_o |-> !speaker_enable_o)
    else $error("speaker on while bypass closed");
  a_pin_low_off: assert property (!enable_pin_i |=> !(amps_on || bias_enable_o || bypass_switch_o))
    else $error("section on after pin low");
  a_soft_sd_off: assert property (soft_shutdown_o |-> !(amps_on || bias_enable_o))
    else $error("section on in soft shutdown");
  a_pump_follows: assert property (charge_pump_enable_o == (left_phone_enable_o || right_phone_enable_o))
    else $error("charge pump mismatch");
  a_sum_always: assert property (speaker_sum_select_o)
    else $error("speaker sum dropped");
  a_bypass_vol_skip: assert property (bypass_switch_o |-> speaker_volume_bypass_o)
    else $error("volume not bypassed");
  a_gain_write: assert property (wr_strobe_i && wr_index_i == 3'h5 |-> ##2
    speaker_gain_high_o == $past(wr_data_i[7], 2) && phone_gain_code_o[3] == $past(wr_data_i[6], 2))
    else $error("gain write not decoded");
  a_mode_write: assert property (wr_strobe_i && wr_index_i == 3'h4 |-> ##2
    mux_mode_o == (8'h01 << $past(wr_data_i[7:5], 2)) && mono_volume_code_o == $past(wr_data_i[4:0], 2))
    else $error("mode write not decoded");
  a_ctrl_write: assert property ((wr_strobe_i && wr_index_i == 3'h1 && enable_pin_i) ##1 enable_pin_i |=>
    left_phone_enable_o == ($past(wr_data_i[3], 2) && !$past(wr_data_i[4], 2)) &&
    speaker_enable_o == ($past(wr_data_i[1], 2) && !$past(wr_data_i[0], 2) && !$past(wr_data_i[4], 2)))
    else $error("control write not decoded");
  c_bypass: cover property (bypass_switch_o && soft_shutdown_o);
  c_mute: cover property (mux_mode_o == 8'h80);
  c_spk: cover property (speaker_enable_o && speaker_gain_high_o);
endmodule // amp_ctrl_properties

bind amp_power_gain_control amp_ctrl_properties i_amp_ctrl_properties (.*);

// >>> sim/host_writer.sv
// host model: hands completed register writes to the block
// assumes the bench calls its tasks from one process
`timescale 1ns/10ps
module host_writer #(
  parameter int SETTLE_CYC = 25000
) (
  // clock
  input wire logic clock_i,
  // write
  output logic wr_strobe_o,
  output logic [2:0] wr_index_o,
  output logic [7:0] wr_data_o
);
  logic [7:0] ctrl_r;
  initial begin
    wr_strobe_o = 1'b0;
    wr_index_o = 3'h0;
    wr_data_o = 8'h00;
    ctrl_r = 8'h00;
  end
  task automatic write_reg(input logic [2:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    wr_strobe_o <= 1'b1;
    wr_index_o <= idx;
    wr_data_o <= d;
    @(posedge clock_i);
    wr_strobe_o <= 1'b0;
    // idle data inverted so nothing relies on stale bytes
    wr_data_o <= ~d;
    if (idx == 3'h1) begin
      if ((ctrl_r[4] && !d[4]) || |(~ctrl_r[3:1] & d[3:1])) repeat (SETTLE_CYC) @(posedge clock_i);
      ctrl_r = d;
    end
  endtask
  task automatic set_mode(input logic [2:0] m, input logic [4:0] v);
    write_reg(3'h4, {3'h7, v});
    write_reg(3'h4, {m, v});
  endtask
endmodule // host_writer

// >>> sim/tb_top.sv
// self-checking bench for amp_power_gain_control
// assumes host_writer and the bound checker
`timescale 1ns/10ps
module tb_top;
  logic clock_i, rst_b_i, pin_r, stb_w;
  logic [2:0] idx_w;
  logic [7:0] dat_w, mux_w;
  logic spk_w, left_w, right_w, byp_w, pump_w, bias_w, gain_w, lim_w;
  logic [3:0] phone_w;
  logic [4:0] mono_w, act_w, app_w, p1_w, p2_w;
  int errors, tests_run;
  typedef struct packed {logic pin; logic [7:0] data; logic [7:0] en;} row_t;
  // expected {speaker, left, right, bypass, pump, bias}
  row_t rows [9] = '{'{1'b1, 8'h0e, 8'h3b}, '{1'b1, 8'h0f, 8'h1f}, '{1'b1, 8'h1e, 8'h00},
    '{1'b1, 8'h11, 8'h04}, '{1'b1, 8'h02, 8'h21}, '{1'b1, 8'h08, 8'h13}, '{1'b1, 8'h04, 8'h0b},
    '{1'b0, 8'h0f, 8'h00}, '{1'b1, 8'h00, 8'h01}};
  logic [4:0] act_exp [8] = '{5'h01, 5'h02, 5'h03, 5'h02, 5'h03, 5'h02, 5'h02, 5'h0d};
  wire logic [7:0] en_w = {2'h0, spk_w, left_w, right_w, byp_w, pump_w, bias_w};
  // short slew period keeps the limiter test quick
  amp_power_gain_control #(.ATTACK_CYC(4), .RELEASE_CYC(4)) i_amp_power_gain_control (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .wr_strobe_i(stb_w), .wr_index_i(idx_w), .wr_data_i(dat_w),
    .enable_pin_i(pin_r), .speaker_enable_o(spk_w), .left_phone_enable_o(left_w),
    .right_phone_enable_o(right_w), .bypass_switch_o(byp_w), .charge_pump_enable_o(pump_w),
    .bias_enable_o(bias_w), .speaker_sum_select_o(), .speaker_gain_high_o(gain_w),
    .speaker_volume_bypass_o(), .phone_gain_code_o(phone_w), .mux_mode_o(mux_w),
    .mono_volume_code_o(mono_w), .pair_one_volume_code_o(p1_w), .pair_two_volume_code_o(p2_w),
    .active_volume_code_o(act_w), .applied_volume_o(app_w), .soft_shutdown_o(), .limiter_enable_o(lim_w));
  // settle wait shortened, the block does not time it
  host_writer #(.SETTLE_CYC(250)) i_host_writer (
    .clock_i(clock_i), .wr_strobe_o(stb_w), .wr_index_o(idx_w), .wr_data_o(dat_w));
  // ----
  // helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    wrap_up();
  end
  // ----
  // main sequence
  // ----
  initial begin
    rst_b_i = 1'b0;
    pin_r = 1'b1;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    settle(1);
    check(8'(mono_w), 8'h0d);
    check(mux_w, 8'h01);
    check(en_w, 8'h01);
    i_host_writer.write_reg(3'h4, 8'hed);
    foreach (rows[i]) begin
      @(posedge clock_i);
      pin_r <= rows[i].pin;
      i_host_writer.write_reg(3'h1, rows[i].data);
      settle(2);
      check(en_w, rows[i].en);
    end
    i_host_writer.write_reg(3'h5, 8'h80);
    settle(2);
    check({3'h0, gain_w, phone_w}, 8'h10);
    i_host_writer.write_reg(3'h6, 8'ha3);
    settle(2);
    check({3'h0, gain_w, phone_w}, 8'h15);
    i_host_writer.write_reg(3'h5, 8'hc2);
    i_host_writer.write_reg(3'h7, 8'hff);
    i_host_writer.write_reg(3'h0, 8'hff);
    settle(2);
    check({3'h0, gain_w, phone_w}, 8'h18);
    check(en_w, 8'h01);
    check({3'h0, p1_w}, 8'h02);
    check({3'h0, p2_w}, 8'h03);
    for (int m = 0; m < 8; m++) begin
      i_host_writer.set_mode(3'(m), 5'h01);
      settle(4);
      check(mux_w, 8'h01 << m);
      check(8'(act_w), 8'(act_exp[m]));
    end
    i_host_writer.set_mode(3'h0, 5'h01);
    settle(4);
    check(8'(app_w), 8'h01);
    i_host_writer.write_reg(3'h2, 8'h00);
    i_host_writer.write_reg(3'h3, 8'h20);
    i_host_writer.write_reg(3'h4, 8'h04);
    settle(3);
    // release code 4 gives 20 cycles a step upward; a jump would already show 04
    check(8'(app_w), 8'h01);
    settle(30);
    check(8'(app_w), 8'h02);
    settle(40);
    check(8'(app_w), 8'h04);
    check(8'(lim_w), 8'h01);
    // attack code 0 gives 4 cycles a step downward
    i_host_writer.write_reg(3'h4, 8'h02);
    settle(3);
    check(8'(app_w), 8'h04);
    settle(20);
    check(8'(app_w), 8'h02);
    i_host_writer.write_reg(3'h4, 8'he4);
    i_host_writer.write_reg(3'h1, 8'h1e);
    i_host_writer.write_reg(3'h1, 8'h0e);
    i_host_writer.write_reg(3'h4, 8'h04);
    settle(2);
    check(en_w, 8'h3b);
    check({4'h0, phone_w}, 8'h08);
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    settle(1);
    check(8'(mono_w), 8'h0d);
    check(en_w, 8'h01);
    wrap_up();
  end
endmodule // tb_top
